//--- core/imtf_pkg.sv
// Constants, command encodings and carrier types for the interrupt
// request front end. Assumes a single core clock domain.
package imtf_pkg;

   localparam int          IMTF_LEVELS    = 8;
   localparam int          IMTF_LVL_W     = 3;
   localparam logic [7:0]  IMTF_MASK_RST  = 8'h00;
   localparam logic [7:0]  IMTF_ISR_RST   = 8'h00;
   localparam logic [7:0]  IMTF_ARMED_RST = 8'hFF;
   localparam logic [2:0]  IMTF_DEFAULT_LVL = 3'h7;

   // Port select: a0 high reaches the mask register directly
   localparam logic        IMTF_A0_MASK   = 1'h1;
   localparam logic        IMTF_A0_CMD    = 1'h0;

   // Command word at a0 low
   localparam int          IMTF_INIT_BIT  = 4;
   localparam int          IMTF_LTIM_BIT  = 3;
   localparam int          IMTF_AEOI_BIT  = 1;
   localparam int          IMTF_SEL_BIT   = 3;
   localparam logic [2:0]  IMTF_EOI_NS    = 3'h1;
   localparam logic [2:0]  IMTF_EOI_SP    = 3'h3;
   localparam logic [1:0]  IMTF_SMM_SET   = 2'h3;
   localparam logic [1:0]  IMTF_SMM_CLR   = 2'h2;
   localparam int          IMTF_OP_LSB    = 5;
   localparam int          IMTF_OP_W      = 3;
   localparam int          IMTF_SMM_W     = 2;
   localparam int          IMTF_LVL_LSB   = 0;

   typedef enum logic [1:0] {
      ACK_IDLE,
      ACK_FIRST,
      ACK_SECOND
   } imtf_ack_e;

   // Everything that arrives from pins, carried through one synchroniser
   typedef struct packed {
      logic       cs_n;
      logic       a0;
      logic       wr_n;
      logic       rd_n;
      logic       ack_n;
      logic [7:0] data;
      logic [7:0] req;
   } imtf_pins_s;

   localparam imtf_pins_s IMTF_PINS_IDLE = '{
      cs_n: 1'h1, a0: 1'h0, wr_n: 1'h1, rd_n: 1'h1, ack_n: 1'h1,
      data: 8'h00, req: 8'h00};

   typedef struct packed {
      logic       hit;
      logic [2:0] lvl;
   } imtf_pick_s;

   // Lowest index wins: level zero has the highest priority
   function automatic imtf_pick_s imtf_highest(input logic [7:0] vec);
      imtf_pick_s p;
      p = '{hit: 1'h0, lvl: 3'h0};
      for (int i = IMTF_LEVELS - 1; i >= 0; i--) begin
         if (vec[i]) begin
            p.hit = 1'h1;
            p.lvl = i[2:0];
         end
      end
      return p;
   endfunction

   // All levels strictly above (numerically below) a given level
   function automatic logic [7:0] imtf_above(input imtf_pick_s p);
      logic [7:0] m;
      m = 8'hFF;
      if (p.hit) begin
         m = 8'h00;
         for (int i = 0; i < IMTF_LEVELS; i++) begin
            if (i < int'(p.lvl)) begin
               m[i] = 1'h1;
            end
         end
      end
      return m;
   endfunction

endpackage

//--- core/imtf_sync.sv
// Two-stage synchroniser for a vector of pin levels.
// Assumes the pins are quasi-static relative to core_clk.
`timescale 1ns/1ps
module imtf_sync #(
   parameter int              WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= INIT;
         sync_out <= INIT;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

//--- core/imtf_front_end.sv
// Request input front end of an eight level interrupt controller:
// mask register, special mask mode, level/edge sensing, in-service
// tracking and the level seven default answer.
// Assumes host bus strobes, acknowledge and requests are raw pins.
`timescale 1ns/1ps
module imtf_front_end
   import imtf_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       cs_n,
   input  wire logic       a0,
   input  wire logic       wr_n,
   input  wire logic       rd_n,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe_n,
   input  wire logic [7:0] request_inputs_0_to_7,
   input  wire logic       interrupt_ack_pulse_n,
   output logic            int_req,
   output logic      [2:0] ack_level,
   output logic            ack_default
);

   // ------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------
   imtf_pins_s pins_raw;
   imtf_pins_s pins_s;
   imtf_pins_s pins_d_reg;

   assign pins_raw = '{cs_n: cs_n, a0: a0, wr_n: wr_n, rd_n: rd_n,
                       ack_n: interrupt_ack_pulse_n, data: data_in,
                       req: request_inputs_0_to_7};

   imtf_sync #(
      .WIDTH ($bits(imtf_pins_s)),
      .INIT  (IMTF_PINS_IDLE)
   ) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .async_in (pins_raw),
      .sync_out (pins_s)
   );

   // Previous synchronised sample, for edges and write data
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_d_reg <= IMTF_PINS_IDLE;
      end else begin
         pins_d_reg <= pins_s;
      end
   end

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Writes commit on the trailing edge, using data held just before
   logic       wr_done;
   logic       wr_mask;
   logic       wr_cmd;
   logic       is_init;
   logic       is_ocw3;
   logic [7:0] wdata;
   logic       ack_fall;
   logic       ack_rise;
   logic [7:0] req_rise;

   // Command fields; meaningful only while wr_cmd is high
   logic [IMTF_OP_W-1:0]  op_code;
   logic [IMTF_SMM_W-1:0] smm_code;
   logic [IMTF_LVL_W-1:0] eoi_lvl;

   assign wr_done  = pins_s.wr_n & ~pins_d_reg.wr_n & ~pins_d_reg.cs_n;
   assign wdata    = pins_d_reg.data;
   assign wr_mask  = wr_done & (pins_d_reg.a0 == IMTF_A0_MASK);
   assign wr_cmd   = wr_done & (pins_d_reg.a0 == IMTF_A0_CMD);
   assign is_init  = wdata[IMTF_INIT_BIT];
   assign is_ocw3  = ~wdata[IMTF_INIT_BIT] & wdata[IMTF_SEL_BIT];
   assign ack_fall = ~pins_s.ack_n & pins_d_reg.ack_n;
   assign ack_rise = pins_s.ack_n & ~pins_d_reg.ack_n;
   assign req_rise = pins_s.req & ~pins_d_reg.req;
   assign op_code  = wdata[IMTF_OP_LSB +: IMTF_OP_W];
   assign smm_code = wdata[IMTF_OP_LSB +: IMTF_SMM_W];
   assign eoi_lvl  = wdata[IMTF_LVL_LSB +: IMTF_LVL_W];

   // ------------------------------------------------------------
   // Mode and mask registers
   // ------------------------------------------------------------
   logic [7:0] level_mask_reg;
   logic       level_mode_reg;
   logic       auto_eoi_reg;
   logic       special_masking_mode_reg;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         level_mask_reg <= IMTF_MASK_RST;
      end else if (wr_cmd && is_init) begin
         level_mask_reg <= IMTF_MASK_RST;
      end else if (wr_mask) begin
         level_mask_reg <= wdata;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         level_mode_reg <= 1'h0;
         auto_eoi_reg   <= 1'h0;
      end else if (wr_cmd && is_init) begin
         level_mode_reg <= wdata[IMTF_LTIM_BIT];
         auto_eoi_reg   <= wdata[IMTF_AEOI_BIT];
      end
   end

   // Mode only leaves on an explicit clear or a fresh initialization
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         special_masking_mode_reg <= 1'h0;
      end else if (wr_cmd && is_init) begin
         special_masking_mode_reg <= 1'h0;
      end else if (wr_cmd && is_ocw3) begin
         if (smm_code == IMTF_SMM_SET) begin
            special_masking_mode_reg <= 1'h1;
         end else if (smm_code == IMTF_SMM_CLR) begin
            special_masking_mode_reg <= 1'h0;
         end
      end
   end

   // ------------------------------------------------------------
   // Priority resolution
   // ------------------------------------------------------------
   logic [7:0] pending_request_reg;
   logic [7:0] in_service_reg;
   logic [7:0] armed_reg;
   logic [7:0] isr_visible;
   logic [7:0] eligible;
   imtf_pick_s isr_top;
   imtf_pick_s winner;

   // Masked in-service levels drop out of nesting in special mask mode
   assign isr_visible = special_masking_mode_reg
                        ? (in_service_reg & ~level_mask_reg)
                        : in_service_reg;
   assign isr_top  = imtf_highest(isr_visible);
   // Mask acts after the pending register, never before it
   assign eligible = pending_request_reg & ~level_mask_reg
                     & imtf_above(isr_top);
   assign winner   = imtf_highest(eligible);

   // ------------------------------------------------------------
   // Request latches
   // ------------------------------------------------------------
   imtf_ack_e  ack_state_reg;
   logic       take_ack;
   logic [7:0] ack_clear;

   assign take_ack  = ack_fall && (ack_state_reg == ACK_IDLE);
   assign ack_clear = (take_ack && winner.hit)
                      ? (8'h01 << winner.lvl) : 8'h00;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_request_reg <= 8'h00;
         armed_reg           <= IMTF_ARMED_RST;
      end else if (level_mode_reg) begin
         // Follows the input, so a dropped request never wins
         pending_request_reg <= pins_s.req;
         armed_reg           <= IMTF_ARMED_RST;
      end else begin
         // Acknowledge disarms the latch and only a low input re-arms
         // it, so a held high level cannot request again
         pending_request_reg <= pins_s.req & ~ack_clear
            & (pending_request_reg | (req_rise & armed_reg));
         armed_reg <= (armed_reg & ~ack_clear) | ~pins_s.req;
      end
   end

   // ------------------------------------------------------------
   // In-service tracking and end of interrupt
   // ------------------------------------------------------------
   logic       eoi_ns;
   logic       eoi_sp;
   logic [7:0] eoi_clear;
   logic [7:0] aeoi_clear;
   logic [7:0] isr_set;
   logic [2:0] served_lvl_reg;
   logic       served_hit_reg;

   assign eoi_ns = wr_cmd && !is_init && !is_ocw3
                   && (op_code == IMTF_EOI_NS);
   assign eoi_sp = wr_cmd && !is_init && !is_ocw3
                   && (op_code == IMTF_EOI_SP);

   always_comb begin
      eoi_clear = 8'h00;
      if (eoi_sp) begin
         eoi_clear = 8'h01 << eoi_lvl;
      end else if (eoi_ns && isr_top.hit) begin
         eoi_clear = 8'h01 << isr_top.lvl;
      end
   end

   assign aeoi_clear = (ack_rise && (ack_state_reg == ACK_SECOND)
                        && auto_eoi_reg && served_hit_reg)
                       ? (8'h01 << served_lvl_reg) : 8'h00;
   // Only acknowledge sets a bit; set wins over a same-cycle clear
   assign isr_set = ack_clear;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_service_reg <= IMTF_ISR_RST;
      end else if (wr_cmd && is_init) begin
         in_service_reg <= IMTF_ISR_RST;
      end else begin
         // In level mode a cleared level re-requests at once if its input is high
         in_service_reg <= (in_service_reg & ~eoi_clear & ~aeoi_clear)
                           | isr_set;
      end
   end

   // ------------------------------------------------------------
   // Acknowledge sequence
   // ------------------------------------------------------------
   // Extra pulses are ignored until the sequence has closed
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_state_reg <= ACK_IDLE;
      end else begin
         case (ack_state_reg)
            ACK_IDLE:   if (ack_fall) ack_state_reg <= ACK_FIRST;
            ACK_FIRST:  if (ack_fall) ack_state_reg <= ACK_SECOND;
            ACK_SECOND: if (ack_rise) ack_state_reg <= ACK_IDLE;
            default:    ack_state_reg <= ACK_IDLE;
         endcase
      end
   end

   // Vanished request still gets an answer, as level seven
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         served_lvl_reg <= IMTF_DEFAULT_LVL;
         served_hit_reg <= 1'h0;
         ack_level      <= IMTF_DEFAULT_LVL;
         ack_default    <= 1'h0;
      end else if (take_ack) begin
         served_hit_reg <= winner.hit;
         served_lvl_reg <= winner.hit ? winner.lvl : IMTF_DEFAULT_LVL;
         ack_level      <= winner.hit ? winner.lvl
                                      : IMTF_DEFAULT_LVL;
         ack_default    <= ~winner.hit;
      end
   end

   // ------------------------------------------------------------
   // Outputs to the host
   // ------------------------------------------------------------
   // Held low during an acknowledge so the host sees one request
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         int_req <= 1'h0;
      end else begin
         int_req <= winner.hit && (ack_state_reg == ACK_IDLE)
                    && !take_ack;
      end
   end

   // Read at a0 high returns the mask; at a0 low the pending levels
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_out  <= 8'h00;
         data_oe_n <= 1'h1;
      end else if (!pins_s.rd_n && !pins_s.cs_n) begin
         data_out  <= (pins_s.a0 == IMTF_A0_MASK)
                      ? level_mask_reg : pending_request_reg;
         data_oe_n <= 1'h0;
      end else begin
         data_out  <= 8'h00;
         data_oe_n <= 1'h1;
      end
   end

endmodule

//--- tb/imtf_assertions.sv
// Port checker for the interrupt request front end.
// Assumes one core_clk domain; bound to imtf_front_end below.
`timescale 1ns/1ps
module imtf_checker
   import imtf_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       cs_n,
   input wire logic       a0,
   input wire logic       wr_n,
   input wire logic       rd_n,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic       data_oe_n,
   input wire logic [7:0] request_inputs_0_to_7,
   input wire logic       interrupt_ack_pulse_n,
   input wire logic       int_req,
   input wire logic [2:0] ack_level,
   input wire logic       ack_default
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ----------------
   // Properties
   // ----------------
   sequence s_ack_fall;
      $fell(interrupt_ack_pulse_n) ##1 !interrupt_ack_pulse_n;
   endsequence
   sequence s_quiet;
      (request_inputs_0_to_7 == 8'h00) [*6];
   endsequence
   property p_rst;
      $rose(rst_n) |-> !int_req && data_oe_n && !ack_default
         && ack_level == 3'h7;
   endproperty
   property p_oe;
      $fell(data_oe_n) |-> !$past(rd_n) && !$past(cs_n);
   endproperty
   property p_zero;
      data_oe_n |-> data_out == 8'h00;
   endproperty
   property p_rise;
      $rose(int_req) |-> $past(request_inputs_0_to_7, 3) != 8'h00
         || $past(request_inputs_0_to_7, 4) != 8'h00;
   endproperty
   property p_idle;
      s_quiet |-> !int_req;
   endproperty
   property p_ack;
      s_ack_fall |-> ##[1:4] !int_req;
   endproperty
   property p_lvl;
      $changed(ack_level) |-> !$past(interrupt_ack_pulse_n, 3)
         || !$past(interrupt_ack_pulse_n, 4);
   endproperty
   property p_def;
      ack_default |-> ack_level == IMTF_DEFAULT_LVL;
   endproperty
   a_rst:  assert property (p_rst)  else $error("bad reset");
   a_oe:   assert property (p_oe)   else $error("oe no read");
   a_zero: assert property (p_zero) else $error("data idle");
   a_rise: assert property (p_rise) else $error("irq no req");
   a_idle: assert property (p_idle) else $error("irq quiet");
   a_ack:  assert property (p_ack)  else $error("irq on ack");
   a_lvl:  assert property (p_lvl)  else $error("lvl moved");
   a_def:  assert property (p_def)  else $error("default");
endmodule
bind imtf_front_end imtf_checker u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .a0(a0),
   .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in), .data_out(data_out),
   .data_oe_n(data_oe_n), .request_inputs_0_to_7(request_inputs_0_to_7),
   .interrupt_ack_pulse_n(interrupt_ack_pulse_n), .int_req(int_req),
   .ack_level(ack_level), .ack_default(ack_default));

//--- tb/imtf_periph.sv
// Peripheral request model driving the request pins.
// Assumes want and early come from the bench on clock edges.
`timescale 1ns/1ps
module imtf_periph
   import imtf_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] want,
   input  wire logic       early,
   input  wire logic       ack_n,
   output logic      [7:0] req
);
   logic [7:0] held_reg;
   logic       ack_d_reg;
   // Hold a raised line until the first ack fall, unless early asks
   // for the misbehaving drop
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         req       <= 8'h00;
         held_reg  <= 8'h00;
         ack_d_reg <= 1'h1;
      end else begin
         ack_d_reg <= ack_n;
         if (ack_d_reg && !ack_n) begin
            held_reg <= 8'h00;
         end else begin
            held_reg <= held_reg | (want & ~req);
         end
         req <= want | (held_reg & ~{8{early}});
      end
   end
endmodule

//--- tb/imtf_front_end_tb.sv
// Self-checking bench for the interrupt request front end.
// Assumes imtf_periph shapes the request pins from want.
`timescale 1ns/1ps
`define CHK(nm, e, g) cmp(nm, e, g);
module imtf_front_end_tb
   import imtf_pkg::*;
;
   logic       core_clk = 1'h0;
   logic       rst_n = 1'h0;
   logic       cs_n = 1'h1;
   logic       a0 = 1'h0;
   logic       wr_n = 1'h1;
   logic       rd_n = 1'h1;
   logic       ack_n = 1'h1;
   logic       early = 1'h0;
   logic [7:0] data_in = 8'h00;
   logic [7:0] want = 8'h00;
   logic [7:0] req, data_out, rd_v;
   logic [2:0] ack_level;
   logic       data_oe_n, int_req, ack_default;
   int         miscompares = 0;
   int         n_checks = 0;
   int         cyc = 0;
   imtf_front_end dut (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n),
      .a0(a0), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in),
      .data_out(data_out), .data_oe_n(data_oe_n),
      .request_inputs_0_to_7(req), .interrupt_ack_pulse_n(ack_n),
      .int_req(int_req), .ack_level(ack_level), .ack_default(ack_default));
   imtf_periph u_periph (.core_clk(core_clk), .rst_n(rst_n), .want(want),
      .early(early), .ack_n(ack_n), .req(req));
   initial forever #50 core_clk = ~core_clk;
   // ----------------
   // Bus and check tasks
   // ----------------
   task automatic cmp(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      #1;
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s exp %0h got %0h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic setw(input logic [7:0] v, input logic e);
      @(posedge core_clk);
      want  <= v;
      early <= e;
   endtask
   // Strobes held four clocks: the pins pass a three stage sampler
   task automatic wr(input logic sel, input logic [7:0] d);
      @(posedge core_clk);
      cs_n    <= 1'h0;
      a0      <= sel;
      data_in <= d;
      wr_n    <= 1'h0;
      tick(4);
      wr_n <= 1'h1;
      tick(4);
      cs_n <= 1'h1;
      tick(4);
   endtask
   task automatic rd(input logic sel, output logic [7:0] d);
      @(posedge core_clk);
      cs_n <= 1'h0;
      a0   <= sel;
      rd_n <= 1'h0;
      tick(5);
      #1;
      d = data_out;
      `CHK("data_oe_n", 1'h0, data_oe_n)
      @(posedge core_clk);
      rd_n <= 1'h1;
      cs_n <= 1'h1;
      tick(5);
      `CHK("data_oe_n_idle", 1'h1, data_oe_n)
   endtask
   task automatic ackp(input logic [2:0] lvl, input logic dflt);
      repeat (2) begin
         @(posedge core_clk);
         ack_n <= 1'h0;
         tick(4);
         ack_n <= 1'h1;
         tick(4);
      end
      `CHK("ack_level", lvl, ack_level)
      `CHK("ack_default", dflt, ack_default)
   endtask
   task automatic irq(input logic e);
      int n;
      n = 0;
      #1;
      while (int_req !== e && n < 16) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      tick(2);
      `CHK("int_req", e, int_req)
   endtask
   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         miscompares++;
         report_and_stop();
      end
   end
   // ----------------
   // Tests
   // ----------------
   initial begin
      tick(4);
      rst_n <= 1'h1;
      rd(IMTF_A0_MASK, rd_v);
      `CHK("mask_rst", 8'h00, rd_v)
      wr(IMTF_A0_CMD, 8'h10);
      wr(IMTF_A0_MASK, 8'hA5);
      rd(IMTF_A0_MASK, rd_v);
      `CHK("mask_rw", 8'hA5, rd_v)
      wr(IMTF_A0_MASK, 8'h08);
      setw(8'h08, 1'h0);
      tick(10);
      irq(1'h0);
      rd(IMTF_A0_CMD, rd_v);
      `CHK("pending", 8'h08, rd_v)
      wr(IMTF_A0_MASK, 8'h00);
      irq(1'h1);
      ackp(3'h3, 1'h0);
      wr(IMTF_A0_CMD, 8'h63);
      tick(10);
      irq(1'h0);
      setw(8'h00, 1'h0);
      tick(6);
      setw(8'h08, 1'h0);
      irq(1'h1);
      ackp(3'h3, 1'h0);
      $display("test edge done");
      // Level 3 stays in service while 5 asks
      setw(8'h28, 1'h0);
      tick(10);
      irq(1'h0);
      wr(IMTF_A0_MASK, 8'h08);
      wr(IMTF_A0_CMD, 8'h68);
      irq(1'h1);
      wr(IMTF_A0_CMD, 8'h20);
      tick(6);
      irq(1'h1);
      wr(IMTF_A0_CMD, 8'h48);
      irq(1'h0);
      wr(IMTF_A0_CMD, 8'h63);
      irq(1'h1);
      ackp(3'h5, 1'h0);
      setw(8'h00, 1'h0);
      wr(IMTF_A0_CMD, 8'h65);
      $display("test special done");
      wr(IMTF_A0_CMD, 8'h18);
      setw(8'h04, 1'h0);
      irq(1'h1);
      ackp(3'h2, 1'h0);
      wr(IMTF_A0_CMD, 8'h20);
      irq(1'h1);
      ackp(3'h2, 1'h0);
      setw(8'h00, 1'h0);
      wr(IMTF_A0_CMD, 8'h20);
      tick(10);
      irq(1'h0);
      $display("test level done");
      setw(8'h40, 1'h1);
      irq(1'h1);
      setw(8'h00, 1'h1);
      tick(6);
      ackp(IMTF_DEFAULT_LVL, 1'h1);
      $display("test default done");
      // Level mode with automatic end of interrupt
      wr(IMTF_A0_CMD, 8'h1A);
      setw(8'h02, 1'h0);
      irq(1'h1);
      ackp(3'h1, 1'h0);
      irq(1'h1);
      setw(8'h00, 1'h0);
      tick(6);
      irq(1'h0);
      $display("test auto done");
      report_and_stop();
   end
endmodule
